// [swref_pkg.sv]
// constants and carriers for the switch status and reference buffer registers
// assumes a single-clock register port, read data one cycle after the strobe
// Contract
// R1: the switch status register is read-only at 0x21bc and resets to zero.
// R2: status bit 11 reads 1 while the feedback return switch is closed.
// R3: status bit 9 reads 1 while switch ten is closed.
// R4: status bit 5 reads 1 while switch six is closed.
// R5: status bit 0 reads 1 while switch one is closed.
// R6: bits 8, 6, 4, 3, 2, 1 show switches nine, seven, five, four, three, two.
// R7: reserved bits of both registers read zero and ignore writes.
// R8: the buffer control register sits at 0x2180 and resets to 0x37.
// R9: control bit 8 enables the buffered 1.82 V reference pin output.
// R10: control bit 6 closes the 1.11 V decoupling discharge switch.
// R11: control bit 5 enables the 1.11 V low-power common-mode buffer.
// R12: software enables high-power buffers while converting, low-power ones in hibernate.
// R13: control bit 4 enables the 1.11 V high-speed common-mode buffer.
// R14: control bit 3 closes the 1.82 V decoupling discharge switch.
// R15: control bit 2 enables the 1.82 V low-power reference buffer.
package swref_pkg;
   localparam logic [15:0] SWREF_ADDR_CTRL   = 16'h2180;
   localparam logic [15:0] SWREF_ADDR_STATUS = 16'h21bc;
   localparam logic [31:0] SWREF_CTRL_RESET  = 32'h0000_0037;
   localparam logic [31:0] SWREF_STAT_RESET  = 32'h0000_0000;
   // writable control bits: 8,6,5,4,3,2,1,0
   localparam logic [31:0] SWREF_CTRL_MASK   = 32'h0000_017f;
   // implemented status bits: 11,9,8,6,5,4,3,2,1,0
   localparam logic [31:0] SWREF_STAT_MASK   = 32'h0000_0b7f;
   localparam int SWREF_BIT_PIN_OUT   = 8;
   localparam int SWREF_BIT_1V11_DIS  = 6;
   localparam int SWREF_BIT_1V11_LP   = 5;
   localparam int SWREF_BIT_1V11_HS   = 4;
   localparam int SWREF_BIT_1V82_DIS  = 3;
   localparam int SWREF_BIT_1V82_LP   = 2;

   typedef struct packed {
      logic ref_1v82_pin_output_enable;
      logic ref_1v11_discharge_close;
      logic ref_1v11_lowpower_buffer_enable;
      logic ref_1v11_highspeed_buffer_enable;
      logic ref_1v82_discharge_close;
      logic ref_1v82_lowpower_buffer_enable;
      logic [1:0] ref_other;
   } swref_ctrl_t;

   typedef struct packed {
      logic [15:0] addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } swref_bus_t;
endpackage

// [swref_regs.sv]
// register bank: switch group status and reference buffer control
// switch states arrive synchronous to clk from the switch matrix, 1 = closed
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/10ps
module swref_regs (
   input  wire logic               clk,
   input  wire logic               rst,
   input  wire swref_pkg::swref_bus_t bus,
   input  wire logic [11:0]        switch_closed,
   output logic [31:0]             rdata,
   output swref_pkg::swref_ctrl_t  ctrl
);
   import swref_pkg::*;

   logic [31:0] ctrl_reg;
   logic [31:0] status_reg;
   logic [31:0] rdata_next;

   // reserved bits masked on write so they always read zero [R7]
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ctrl_reg <= SWREF_CTRL_RESET; // [R8]
      end else if (bus.wr && bus.addr == SWREF_ADDR_CTRL) begin
         ctrl_reg <= bus.wdata & SWREF_CTRL_MASK; // [R7]
      end
   end

   // status is read-only; writes to it fall through [R1]
   // bits map straight from the switch vector [R2] [R3] [R4] [R5] [R6]
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         status_reg <= SWREF_STAT_RESET; // [R1]
      end else begin
         status_reg <= {20'h0_0000, switch_closed} & SWREF_STAT_MASK; // [R7]
      end
   end

   always_comb begin
      rdata_next = 32'h0000_0000;
      if (bus.rd) begin
         case (bus.addr)
            SWREF_ADDR_CTRL:   rdata_next = ctrl_reg;
            SWREF_ADDR_STATUS: rdata_next = status_reg;
            default:           rdata_next = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rdata <= 32'h0000_0000;
      end else begin
         rdata <= rdata_next;
      end
   end

   // outputs use their own flops loaded with the control register's next value, no extra stage
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ctrl <= swref_ctrl_t'(8'h37);
      end else begin
         ctrl.ref_1v82_pin_output_enable <=
            ctrl_next_bit(SWREF_BIT_PIN_OUT); // [R9]
         ctrl.ref_1v11_discharge_close <=
            ctrl_next_bit(SWREF_BIT_1V11_DIS); // [R10]
         ctrl.ref_1v11_lowpower_buffer_enable <=
            ctrl_next_bit(SWREF_BIT_1V11_LP); // [R11]
         ctrl.ref_1v11_highspeed_buffer_enable <=
            ctrl_next_bit(SWREF_BIT_1V11_HS); // [R13]
         ctrl.ref_1v82_discharge_close <=
            ctrl_next_bit(SWREF_BIT_1V82_DIS); // [R14]
         ctrl.ref_1v82_lowpower_buffer_enable <=
            ctrl_next_bit(SWREF_BIT_1V82_LP); // [R15]
         ctrl.ref_other <= {ctrl_next_bit(1), ctrl_next_bit(0)};
      end
   end

   // value the control register takes at this edge
   function automatic logic ctrl_next_bit(input int idx);
      logic [31:0] v;
      v = (bus.wr && bus.addr == SWREF_ADDR_CTRL) ?
          (bus.wdata & SWREF_CTRL_MASK) : ctrl_reg;
      return v[idx];
   endfunction

   a_status_reads: assert property (@(posedge clk) disable iff (rst)
      $past(bus.rd) && $past(bus.addr) == SWREF_ADDR_STATUS
      |-> rdata == $past(status_reg))
      else $error("status read data wrong"); // [R1]
   a_status_map: assert property (@(posedge clk) disable iff (rst)
      ##1 status_reg == ({20'h0_0000, $past(switch_closed)} & SWREF_STAT_MASK))
      else $error("status bit map wrong"); // [R2]
   a_ctrl_write: assert property (@(posedge clk) disable iff (rst)
      bus.wr && bus.addr == SWREF_ADDR_CTRL
      |=> ctrl_reg == ($past(bus.wdata) & SWREF_CTRL_MASK))
      else $error("control write lost"); // [R7]
   a_ctrl_hold: assert property (@(posedge clk) disable iff (rst)
      !(bus.wr && bus.addr == SWREF_ADDR_CTRL) |=> $stable(ctrl_reg))
      else $error("control changed without write"); // [R8]
   a_pin_out: assert property (@(posedge clk) disable iff (rst)
      ##1 ctrl.ref_1v82_pin_output_enable == ctrl_reg[SWREF_BIT_PIN_OUT])
      else $error("pin output enable mismatch"); // [R9]
   a_dis_1v11: assert property (@(posedge clk) disable iff (rst)
      ##1 ctrl.ref_1v11_discharge_close == ctrl_reg[SWREF_BIT_1V11_DIS])
      else $error("1v11 discharge mismatch"); // [R10]
   a_lp_1v11: assert property (@(posedge clk) disable iff (rst)
      ##1 ctrl.ref_1v11_lowpower_buffer_enable == ctrl_reg[SWREF_BIT_1V11_LP])
      else $error("1v11 lp buffer mismatch"); // [R11]
   a_hs_1v11: assert property (@(posedge clk) disable iff (rst)
      ##1 ctrl.ref_1v11_highspeed_buffer_enable == ctrl_reg[SWREF_BIT_1V11_HS])
      else $error("1v11 hs buffer mismatch"); // [R13]
   a_dis_1v82: assert property (@(posedge clk) disable iff (rst)
      ##1 ctrl.ref_1v82_discharge_close == ctrl_reg[SWREF_BIT_1V82_DIS])
      else $error("1v82 discharge mismatch"); // [R14]
   a_lp_1v82: assert property (@(posedge clk) disable iff (rst)
      ##1 ctrl.ref_1v82_lowpower_buffer_enable == ctrl_reg[SWREF_BIT_1V82_LP])
      else $error("1v82 lp buffer mismatch"); // [R15]
endmodule

// [swref_host.sv]
// host model: software-side master of the register port
// assumes clk from the bench; read data one cycle after the strobe
`timescale 1ns/10ps
module swref_host (
   input  wire logic             clk,
   output swref_pkg::swref_bus_t bus,
   input  wire logic [31:0]      rdata
);
   import swref_pkg::*;
   initial bus = '0;
   // ends on a falling edge so callers sample settled outputs
   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      @(posedge clk) bus <= '{a, d, 1'b1, 1'b0};
      @(posedge clk) bus.wr <= 1'b0;
      @(negedge clk);
   endtask
   task automatic rd(input logic [15:0] a, output logic [31:0] d);
      @(posedge clk) bus <= '{a, 32'h0000_0000, 1'b0, 1'b1};
      @(posedge clk) bus.rd <= 1'b0;
      @(negedge clk) d = rdata;
   endtask
endmodule

// [swref_regs_test.sv]
// self-checking bench for the status and buffer control registers
// assumes the host model for bus cycles; switches driven directly
`timescale 1ns/10ps
module swref_regs_test;
   import swref_pkg::*;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic [11:0] switch_closed = 12'h000;
   logic [31:0] rdata;
   logic [31:0] d;
   swref_bus_t  bus;
   swref_ctrl_t ctrl;
   int          mismatches = 0;
   int          checks_done = 0;
   int          cycles = 0;
   int          b[6] = '{8, 6, 5, 4, 3, 2};
   always #5 clk = ~clk;
   swref_regs swref_regs_i (.clk(clk), .rst(rst), .bus(bus),
      .switch_closed(switch_closed), .rdata(rdata), .ctrl(ctrl));
   swref_host swref_host_i (.clk(clk), .bus(bus), .rdata(rdata));
   task automatic chk(string n, logic [31:0] e, logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic finish_test();
      $display("mismatches %0d checks %0d", mismatches, checks_done);
      if (mismatches == 0 && checks_done > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic test_reset();
      chk("ctrl port", 32'h0000_0037, {24'h00_0000, ctrl});
      swref_host_i.rd(SWREF_ADDR_CTRL, d);
      chk("ctrl read", 32'h0000_0037, d);
      swref_host_i.rd(SWREF_ADDR_STATUS, d);
      chk("status read", 32'h0000_0000, d);
   endtask
   task automatic test_status();
      for (int i = 0; i < 13; i++) begin
         @(posedge clk) switch_closed <= (i == 12) ? 12'hfff : 12'h001 << i;
         swref_host_i.rd(SWREF_ADDR_STATUS, d);
         chk("status", (i == 12) ? 32'h0000_0b7f :
            (i == 10 || i == 7) ? 32'h0 : 32'h1 << i, d);
      end
      swref_host_i.wr(SWREF_ADDR_STATUS, 32'h0000_0000);
      swref_host_i.rd(SWREF_ADDR_STATUS, d);
      chk("status ro", 32'h0000_0b7f, d);
   endtask
   task automatic test_ctrl();
      swref_host_i.wr(SWREF_ADDR_CTRL, 32'hffff_ffff);
      chk("ctrl port", 32'h0000_00ff, {24'h00_0000, ctrl});
      swref_host_i.rd(SWREF_ADDR_CTRL, d);
      chk("ctrl reserved", 32'h0000_017f, d);
      foreach (b[k]) begin
         swref_host_i.wr(SWREF_ADDR_CTRL, 32'h1 << b[k]);
         chk("ctrl field", 32'h80 >> k, {24'h00_0000, ctrl});
         swref_host_i.rd(SWREF_ADDR_CTRL, d);
         chk("ctrl back", 32'h1 << b[k], d);
      end
      swref_host_i.rd(16'h2184, d);
      chk("unmapped", 32'h0000_0000, d);
      swref_host_i.wr(SWREF_ADDR_CTRL, 32'h0000_0037);
      chk("ctrl port", 32'h0000_0037, {24'h00_0000, ctrl});
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 2000) begin
         mismatches++;
         finish_test();
      end
   end
   initial begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      test_reset();
      test_status();
      test_ctrl();
      finish_test();
   end
endmodule
